// *** tb/adaptive_on_time_buck_control_bench.sv ***
// Self-checking bench for the buck controller with a switch-pair model.
// Assumes the port monitor is bound into the controller.
`timescale 1ns/10ps
module adaptive_on_time_buck_control_bench;
  logic        clk_sys_in = 1'b0;
  logic        srst_in = 1'b1;
  logic        fsense = 1'b0;
  logic        hard_short = 1'b0;
  logic [11:0] ton = 12'h005;
  logic [11:0] psi = 12'h000;
  logic        oc, hs, ls, ssa, atc, shoot;
  logic [6:0]  refc;
  logic [11:0] sns;
  int          miscompares = 0;
  int          checks = 0;
  int          n, w;
  always #10 clk_sys_in = ~clk_sys_in;
  aot_buck_ctrl #(.SS_STEP_CYC(4)) uut (.clk_sys_in, .srst_in, .feedback_sense_low_in(fsense),
    .ton_cycles_in(ton), .power_stage_input_in(psi), .over_current_in(oc),
    .high_side_drive_out(hs), .low_side_drive_out(ls), .ref_code_out(refc),
    .soft_start_active_out(ssa), .sense_clamped_out(sns), .sense_at_clamp_out(atc));
  aot_fet_pair fets (.high_gate_in(hs), .low_gate_in(ls), .hard_short_in(hard_short),
    .over_current_out(oc), .shoot_through_out(shoot));
  task automatic check(string name, logic [11:0] seen, logic [11:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Counts edges until the high drive reaches v, sampling after updates land
  task automatic wait_hs(logic v, output int c);
    c = 0;
    while (hs !== v && c < 200) begin
      @(posedge clk_sys_in);
      #1;
      c++;
    end
  endtask
  task automatic t_soft();
    n = 0;
    while (refc !== 7'h53 && n < 500) begin
      @(posedge clk_sys_in);
      #1;
      n++;
    end
    check("ss_time", 12'(n inside {[328:336]}), 12'h001);
    repeat (20) @(posedge clk_sys_in);
    check("ref_hold", 12'(refc), 12'h053);
    check("ss_active", 12'(ssa), 12'h000);
  endtask
  task automatic t_pulse();
    @(posedge clk_sys_in);
    fsense <= 1'b1;
    @(posedge clk_sys_in);
    fsense <= 1'b0;
    wait_hs(1'b1, n);
    check("on_delay", 12'(n <= 3), 12'h001);
    check("low_in_on", 12'(ls), 12'h000);
    wait_hs(1'b0, w);
    check("on_width", 12'(w), 12'h005);
    repeat (3) @(posedge clk_sys_in);
    check("low_in_off", 12'(ls), 12'h001);
  endtask
  // Late request, ton changed mid-pulse, then feedback held low
  task automatic t_back_to_back();
    repeat (40) @(posedge clk_sys_in);
    fsense <= 1'b1;
    wait_hs(1'b1, n);
    ton <= 12'h009;
    check("late_req", 12'(n <= 4), 12'h001);
    wait_hs(1'b0, w);
    check("held_width", 12'(w), 12'h005);
    wait_hs(1'b1, n);
    check("min_off", 12'(n inside {[19:24]}), 12'h001);
    fsense <= 1'b0;
    wait_hs(1'b0, w);
    check("new_width", 12'(w), 12'h009);
  endtask
  task automatic t_hiccup();
    @(posedge clk_sys_in);
    hard_short <= 1'b1;
    repeat (5) @(posedge clk_sys_in);
    check("blanked", 12'(ls), 12'h001);
    // Looked at before the restarted staircase takes its first step
    repeat (8) @(posedge clk_sys_in);
    check("hiccup_ref", 12'(refc), 12'h000);
    check("hiccup_low", 12'(ls), 12'h000);
    hard_short <= 1'b0;
    psi <= 12'hABC;
    repeat (2) @(posedge clk_sys_in);
    check("sense", sns, 12'hABC);
    check("at_clamp", 12'(atc), 12'h000);
  endtask
  always @(posedge clk_sys_in) if (shoot === 1'b1) check("shoot", 12'h001, 12'h000);
  initial begin
    #60000;
    miscompares++;
    finish_test();
  end
  initial begin
    repeat (16) @(posedge clk_sys_in);
    check("rst_drives", {10'h000, hs, ls}, 12'h000);
    check("rst_ref", {4'h0, refc, ssa}, 12'h001);
    srst_in <= 1'b0;
    t_soft();
    t_pulse();
    t_back_to_back();
    t_hiccup();
    finish_test();
  end
endmodule

// *** tb/aot_buck_monitor.sv ***
// Port assertions for the adaptive on-time buck controller.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/10ps
module aot_buck_monitor #(
  parameter int unsigned TON_W = 12
) (
  // Clock and reset
  input wire logic             clk_sys_in,
  input wire logic             srst_in,
  // Loop inputs
  input wire logic             feedback_sense_low_in,
  input wire logic [TON_W-1:0] ton_cycles_in,
  input wire logic [11:0]      power_stage_input_in,
  input wire logic             over_current_in,
  // Outputs
  input wire logic             high_side_drive_out,
  input wire logic             low_side_drive_out,
  input wire logic [6:0]       ref_code_out,
  input wire logic             soft_start_active_out,
  input wire logic [11:0]      sense_clamped_out,
  input wire logic             sense_at_clamp_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (srst_in);
  logic [TON_W:0]   on_cnt_reg;
  logic [TON_W-1:0] ton_reg;
  logic [4:0]       off_cnt_reg;
  logic [4:0]       low_cnt_reg;
  always_ff @(posedge clk_sys_in) begin
    on_cnt_reg <= high_side_drive_out ? on_cnt_reg + 1'b1 : '0;
  end
  always_ff @(posedge clk_sys_in) begin
    // Estimate is latched on the edge that raises the drive, one edge before the rise is seen
    if ($rose(high_side_drive_out)) ton_reg <= $past(ton_cycles_in);
  end
  // Saturates so the first pulse after reset is never judged short
  always_ff @(posedge clk_sys_in) begin
    if (srst_in || (!high_side_drive_out && off_cnt_reg != 5'h1F)) begin
      off_cnt_reg <= srst_in ? 5'h1F : off_cnt_reg + 5'h01;
    end else if (high_side_drive_out) begin
      off_cnt_reg <= 5'h00;
    end
  end
  always_ff @(posedge clk_sys_in) begin
    low_cnt_reg <= !low_side_drive_out ? 5'h00 :
                   (low_cnt_reg == 5'h1F ? 5'h1F : low_cnt_reg + 5'h01);
  end
  chk_on_start: assert property ((!high_side_drive_out && !low_side_drive_out)[*3] ##0
    (feedback_sense_low_in && ref_code_out != 7'h00) |-> ##[1:3] high_side_drive_out)
    else $error("on-interval not started");
  chk_on_length: assert property ($fell(high_side_drive_out) |->
    on_cnt_reg == ((ton_reg == '0) ? (TON_W+1)'(1) : {1'b0, ton_reg})) else $error("on-interval length wrong");
  chk_off_after_on: assert property ($fell(high_side_drive_out) |->
    (!low_side_drive_out)[*2] ##1 low_side_drive_out) else $error("off-interval entry wrong");
  chk_min_off_gap: assert property ($rose(high_side_drive_out) |-> off_cnt_reg >= 5'h13)
    else $error("off-interval too short");
  chk_no_overlap: assert property (!(high_side_drive_out && low_side_drive_out))
    else $error("both drives on");
  chk_blank_hold: assert property ((low_side_drive_out && over_current_in && low_cnt_reg < 5'h08
    && !feedback_sense_low_in) |=> low_side_drive_out) else $error("over-current acted inside blanking");
  chk_hiccup_restart: assert property ((low_side_drive_out && over_current_in && low_cnt_reg >= 5'h08)
    |-> ##[1:2] (ref_code_out == 7'h00 && !high_side_drive_out)) else $error("no hiccup restart");
  chk_ref_step: assert property ($changed(ref_code_out) |->
    ref_code_out == $past(ref_code_out) + 7'h01 || ref_code_out == 7'h00) else $error("bad ref step");
  chk_ref_final: assert property ((ref_code_out == 7'h53 && $past(ref_code_out) == 7'h53)
    |-> !soft_start_active_out ##1 ref_code_out inside {7'h53, 7'h00}) else $error("ref not held");
  chk_sense_pass: assert property (!$past(srst_in) |-> sense_clamped_out == $past(power_stage_input_in)
    && !sense_at_clamp_out) else $error("sense path wrong");
  cov_pulse: cover property ($fell(high_side_drive_out));
  cov_hiccup: cover property (over_current_in && low_cnt_reg >= 5'h08);
  cov_full_ref: cover property (ref_code_out == 7'h53);
endmodule
bind aot_buck_ctrl aot_buck_monitor #(.TON_W(TON_W)) u_mon (.clk_sys_in, .srst_in, .feedback_sense_low_in,
  .ton_cycles_in, .power_stage_input_in, .over_current_in, .high_side_drive_out, .low_side_drive_out,
  .ref_code_out, .soft_start_active_out, .sense_clamped_out, .sense_at_clamp_out);

// *** tb/aot_fet_pair.sv ***
// Behavioural model of the external high and low power switches.
// Assumes gate drives come straight from the controller outputs.
`timescale 1ns/10ps
module aot_fet_pair (
  // Gate drives
  input  wire logic high_gate_in,
  input  wire logic low_gate_in,
  // Load condition commanded by the bench
  input  wire logic hard_short_in,
  // Sensed results
  output logic      over_current_out,
  output logic      shoot_through_out
);
  // Current is sensed across the low switch, so only while it conducts
  assign over_current_out  = low_gate_in & hard_short_in;
  assign shoot_through_out = high_gate_in & low_gate_in;
endmodule

// *** verilog/aot_buck_ctrl.sv ***
// Adaptive on-time buck controller: drive sequencing, soft-start, hiccup.
// Assumes comparator, estimator count and over-current inputs are synchronous.
// What this block does
// - A low-feedback comparator report starts an on-interval with high side on, low side off.
// - Each on-interval lasts the estimator length, output voltage over input times 300 kHz.
// - After the on-interval, an off-interval drives high side off and low side on.
// - A new low-feedback report ends the off-interval and starts the next on-interval.
// - Every off-interval lasts at least 363 ns; earlier requests wait until then.
// - Feedback still low at the end of an on-interval gives only the minimum off-interval.
// - The input sense code passes through a registered clamp whose limit is 12'hFFF, full scale, so it never clamps.
// - At start-up the reference climbs from zero to 0.8 V in 9.7 mV steps over about 6 ms.
// - At full value the soft-start stops and the reference holds its final level.
// - Over-current in the off-interval after 150 ns blanking turns the low side off and restarts soft-start.
// - 40 ns dead time (30 ns rounded up to two cycles) separates one drive turning off from the other turning on.
`timescale 1ns/10ps
module aot_buck_ctrl #(
  parameter int unsigned TON_W       = aot_pkg::TON_W,
  parameter int unsigned SS_STEP_CYC = aot_pkg::SS_STEP_CYC
) (
  // Clock and reset
  input  wire logic                        clk_sys_in,
  input  wire logic                        srst_in,
  // Loop inputs
  input  wire logic                        feedback_sense_low_in,
  input  wire logic [TON_W-1:0]            ton_cycles_in,
  input  wire logic [aot_pkg::SENSE_W-1:0] power_stage_input_in,
  input  wire logic                        over_current_in,
  // Gate drives
  output logic                             high_side_drive_out,
  output logic                             low_side_drive_out,
  // Reference and status
  output logic [aot_pkg::REF_W-1:0]        ref_code_out,
  output logic                             soft_start_active_out,
  output logic [aot_pkg::SENSE_W-1:0]      sense_clamped_out,
  output logic                             sense_at_clamp_out
);
  localparam int unsigned CNT_W = 24;
  localparam logic [CNT_W-1:0] TOFF_CNT  = CNT_W'(aot_pkg::TOFF_MIN_CYC);
  localparam logic [CNT_W-1:0] BLANK_CNT = CNT_W'(aot_pkg::BLANK_CYC);
  localparam logic [CNT_W-1:0] DEAD_CNT  = CNT_W'(aot_pkg::DEAD_CYC);
  localparam logic [CNT_W-1:0] STEP_CNT  = CNT_W'(SS_STEP_CYC);
  localparam logic [aot_pkg::REF_W-1:0] REF_TOP = aot_pkg::REF_W'(aot_pkg::REF_STEPS);

  initial begin
    if (TON_W < 2 || TON_W > CNT_W || SS_STEP_CYC < 1 || SS_STEP_CYC >= (1 << CNT_W)) begin
      $error("aot_buck_ctrl: unsupported parameter values");
    end
  end

  aot_pkg::aot_state_t state_reg;
  aot_pkg::aot_state_t state_next;
  logic [CNT_W-1:0]           phase_cnt_reg;
  logic [TON_W-1:0]           ton_hold_reg;
  logic [CNT_W-1:0]           ss_cnt_reg;
  logic                       ss_done_reg;
  logic                       oc_trip;
  logic                       phase_end;

  // Sense path clamp lives in its own module
  aot_clamp #(
    .W (aot_pkg::SENSE_W)
  ) u_clamp (
    .clk_sys_in  (clk_sys_in),
    .srst_in     (srst_in),
    .sense_in    (power_stage_input_in),
    .limit_in    (aot_pkg::SENSE_CLAMP_CODE),
    .sense_out   (sense_clamped_out),
    .clamped_out (sense_at_clamp_out)
  );

  // Over-current only counts once the blanking window has passed
  assign oc_trip = (state_reg == aot_pkg::AOT_ST_OFF) && over_current_in &&
                   (phase_cnt_reg >= BLANK_CNT);

  always_comb begin
    phase_end  = 1'b0;
    state_next = state_reg;
    case (state_reg)
      aot_pkg::AOT_ST_IDLE: begin
        // Switching waits until the reference starts to climb
        if (feedback_sense_low_in && ref_code_out != '0) begin
          state_next = aot_pkg::AOT_ST_DTH;
        end
      end
      aot_pkg::AOT_ST_DTH: begin
        if (phase_cnt_reg + 1'b1 >= DEAD_CNT) begin
          state_next = aot_pkg::AOT_ST_ON;
        end
      end
      aot_pkg::AOT_ST_ON: begin
        phase_end = (phase_cnt_reg + 1'b1 >= CNT_W'(ton_hold_reg));
        if (phase_end) begin
          state_next = aot_pkg::AOT_ST_DTL;
        end
      end
      aot_pkg::AOT_ST_DTL: begin
        if (phase_cnt_reg + 1'b1 >= DEAD_CNT) begin
          state_next = aot_pkg::AOT_ST_OFF;
        end
      end
      aot_pkg::AOT_ST_OFF: begin
        // Off-interval counts from dead time start, so dead time is inside the minimum
        if (oc_trip) begin
          state_next = aot_pkg::AOT_ST_IDLE;
        end else if (feedback_sense_low_in && phase_cnt_reg + DEAD_CNT >= TOFF_CNT) begin
          state_next = aot_pkg::AOT_ST_DTH;
        end
      end
      default: state_next = aot_pkg::AOT_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      state_reg <= aot_pkg::AOT_ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Phase counter restarts at every state change
  always_ff @(posedge clk_sys_in) begin
    if (srst_in || state_next != state_reg) begin
      phase_cnt_reg <= '0;
    end else if (phase_cnt_reg != {CNT_W{1'b1}}) begin
      phase_cnt_reg <= phase_cnt_reg + 1'b1;
    end
  end

  // Estimate taken once; changes mid-interval have no effect
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      ton_hold_reg <= TON_W'(1);
    end else if (state_reg == aot_pkg::AOT_ST_DTH && state_next == aot_pkg::AOT_ST_ON) begin
      ton_hold_reg <= (ton_cycles_in == '0) ? TON_W'(1) : ton_cycles_in;
    end
  end

  // Drives come straight from flops; both low outside on and off phases
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      high_side_drive_out <= 1'b0;
      low_side_drive_out  <= 1'b0;
    end else begin
      high_side_drive_out <= (state_next == aot_pkg::AOT_ST_ON);
      low_side_drive_out  <= (state_next == aot_pkg::AOT_ST_OFF);
    end
  end

  // Soft-start staircase; a hiccup restarts it from zero
  always_ff @(posedge clk_sys_in) begin
    if (srst_in || oc_trip) begin
      ref_code_out          <= '0;
      ss_cnt_reg            <= '0;
      ss_done_reg           <= 1'b0;
      soft_start_active_out <= 1'b1;
    end else if (!ss_done_reg) begin
      if (ss_cnt_reg + 1'b1 >= STEP_CNT) begin
        ss_cnt_reg <= '0;
        if (ref_code_out + 1'b1 >= REF_TOP) begin
          ref_code_out          <= REF_TOP;
          ss_done_reg           <= 1'b1;
          soft_start_active_out <= 1'b0;
        end else begin
          ref_code_out <= ref_code_out + 1'b1;
        end
      end else begin
        ss_cnt_reg <= ss_cnt_reg + 1'b1;
      end
    end
  end
endmodule

// *** verilog/aot_clamp.sv ***
// Clamp of the divided power-stage input sense code.
// Assumes the sense code arrives synchronous to clk_sys_in.
`timescale 1ns/10ps
module aot_clamp #(
  parameter int unsigned W = aot_pkg::SENSE_W
) (
  // Clock and reset
  input  wire logic         clk_sys_in,
  input  wire logic         srst_in,
  // Sense path
  input  wire logic [W-1:0] sense_in,
  input  wire logic [W-1:0] limit_in,
  output logic      [W-1:0] sense_out,
  output logic              clamped_out
);
  // Code above the limit stands for an input above 30 V
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      sense_out   <= '0;
      clamped_out <= 1'b0;
    end else if (sense_in > limit_in) begin
      sense_out   <= limit_in;
      clamped_out <= 1'b1;
    end else begin
      sense_out   <= sense_in;
      clamped_out <= 1'b0;
    end
  end
endmodule

// *** verilog/aot_pkg.sv ***
// Constants for the adaptive on-time buck control block.
// Assumes a 50 MHz system clock; all counts are derived from it.
package aot_pkg;
  localparam int unsigned CLK_FREQ_HZ     = 50000000;
  localparam int unsigned CLK_PERIOD_PS   = 1000000000 / (CLK_FREQ_HZ / 1000);
  // Minimum off-interval, rounded up to whole cycles
  localparam int unsigned TOFF_MIN_PS     = 363000;
  localparam int unsigned TOFF_MIN_CYC    = (TOFF_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // Current-sense blanking after the off-interval starts, least time rounded up
  localparam int unsigned BLANK_PS        = 150000;
  localparam int unsigned BLANK_CYC       = (BLANK_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // Dead time between drives, rounded up
  localparam int unsigned DEAD_PS         = 30000;
  localparam int unsigned DEAD_CYC        = (DEAD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // Soft-start: 0.8 V reached in 9.7 mV steps over about 6 ms
  localparam int unsigned REF_FULL_UV     = 800000;
  localparam int unsigned REF_STEP_UV     = 9700;
  localparam int unsigned REF_STEPS       = (REF_FULL_UV + REF_STEP_UV - 1) / REF_STEP_UV;
  localparam int unsigned SS_PERIOD_US    = 6000;
  localparam int unsigned SS_STEP_CYC     = (SS_PERIOD_US * (CLK_FREQ_HZ / 1000000)) / REF_STEPS;
  // Estimator figures kept for reference: 300 kHz nominal, 30 V clamp, 6:1 divider
  localparam int unsigned FSW_HZ          = 300000;
  localparam int unsigned VCLAMP_MV       = 30000;
  localparam int unsigned SENSE_DIV       = 6;
  localparam int unsigned SENSE_CLAMP_MV  = VCLAMP_MV / SENSE_DIV;
  // Widths
  localparam int unsigned TON_W           = 12;
  localparam int unsigned REF_W           = 7;
  localparam int unsigned SENSE_W         = 12;
  localparam logic [SENSE_W-1:0] SENSE_CLAMP_CODE = 12'hFFF;
  typedef enum logic [4:0] {
    AOT_ST_IDLE = 5'b00001,
    AOT_ST_DTH  = 5'b00010,
    AOT_ST_ON   = 5'b00100,
    AOT_ST_DTL  = 5'b01000,
    AOT_ST_OFF  = 5'b10000
  } aot_state_t;
endpackage
